/* File: bench/rpds_far_side.sv */
/*
 * far-side model: supply monitor, reset pin driver and test host
 * assumes rpds_pkg compiled first; inputs change just after aclk rises
 */
`timescale 1ns/1ps

module rpds_far_side #(
	parameter int SCAN_WAIT = 50000
) (
	// clock
	input  wire logic                   aclk,
	// commands from the bench
	input  wire logic [2:0]             brown_level,
	input  wire logic                   rst_drop,
	input  wire logic                   power_ok,
	input  wire logic                   pin_go,
	input  wire logic [7:0]             pin_len,
	input  wire logic                   scan_req,
	// lines into the block, and scan_ready back to the bench
	output rpds_pkg::rpds_supply_t      supply,
	output logic                        reset_pin_n,
	output logic                        scan_ready
);
	int         up_cnt = 0;
	logic [7:0] low_cnt = 8'h00;

	// ************
	// power-up wait and pin pulse timing
	// ************
	// cycles since supply became usable
	always_ff @(posedge aclk)
	begin
		if (!power_ok)
			up_cnt <= 0;
		else if (up_cnt < SCAN_WAIT)
			up_cnt <= up_cnt + 1;
	end

	// low pulse of pin_len cycles
	always_ff @(posedge aclk)
	begin
		if (pin_go)
			low_cnt <= pin_len;
		else if (low_cnt != 8'h00)
			low_cnt <= low_cnt - 8'h01;
	end

	// host scans only after the power-up wait, driving the pin low
	assign scan_ready  = (up_cnt >= SCAN_WAIT);
	assign reset_pin_n = !((low_cnt != 8'h00) || (scan_req && scan_ready));
	assign supply      = '{below_irq: brown_level, below_rst: rst_drop, supply_ok: power_ok};
endmodule : rpds_far_side

/* File: bench/tb_top.sv */
/*
 * self-checking bench for rpds_top with the far-side model
 * assumes rpds_pkg and rpds_cfg.svh on the include path
 */
`timescale 1ns/1ps
`include "rpds_cfg.svh"
`define RPDS_CMP(nm, ex, got) \
	begin \
		num_checks++; \
		if ((got) !== (ex)) \
		begin \
			n_fail++; \
			$display("Error %s expected %h seen %h", nm, ex, got); \
		end \
	end

module tb_top;
	typedef struct packed {
		logic [1:0]  resp;
		logic [31:0] data;
		logic [31:0] mask;
	} rpds_note_t;

	logic        aclk = 1'h0, aresetn = 1'h0, watchdog_rst = 1'h0, sector0_target = 1'h0;
	logic [31:0] guard_word = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata, fetch_addr;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        chip_rst_n, osc_enable, flash_init, brownout_irq, isp_sector0_ok;
	logic        swd_enable, bscan_enable, tap_pin_route, bscan_cpu_debug, reset_pin_n, scan_ready;
	logic [2:0]  brown_level = 3'h0;
	logic        rst_drop = 1'h0, power_ok = 1'h1, pin_go = 1'h0, scan_req = 1'h0;
	logic [7:0]  pin_len = 8'h00, lfsr_q = 8'h60;
	int          n_fail = 0, num_checks = 0, i, t, lv;
	rpds_pkg::rpds_perm_t   perm;
	rpds_pkg::rpds_supply_t supply;
	rpds_note_t  rq[$], wq[$], nt;
	logic [31:0] pats[5];

	// ************
	// clock, design and far side
	// ************
	always #2.5 aclk = ~aclk;
	rpds_top u_rpds_top (
		.aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
		.watchdog_rst(watchdog_rst), .supply(supply), .guard_word(guard_word),
		.sector0_target(sector0_target),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.chip_rst_n(chip_rst_n), .osc_enable(osc_enable), .flash_init(flash_init),
		.fetch_addr(fetch_addr), .brownout_irq(brownout_irq), .perm(perm),
		.isp_sector0_ok(isp_sector0_ok), .swd_enable(swd_enable),
		.bscan_enable(bscan_enable), .tap_pin_route(tap_pin_route),
		.bscan_cpu_debug(bscan_cpu_debug)
	);
	rpds_far_side u_rpds_far_side (
		.aclk(aclk), .brown_level(brown_level), .rst_drop(rst_drop), .power_ok(power_ok),
		.pin_go(pin_go), .pin_len(pin_len), .scan_req(scan_req), .supply(supply),
		.reset_pin_n(reset_pin_n), .scan_ready(scan_ready)
	);

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next

	// ************
	// monitor: bus answers against the oldest note
	// ************
	always @(negedge aclk)
	begin
		if (s_axi_rvalid === 1'h1 && s_axi_rready && rq.size() > 0)
		begin
			nt = rq.pop_front();
			`RPDS_CMP("rresp", nt.resp, s_axi_rresp)
			`RPDS_CMP("rdata", nt.data, s_axi_rdata & nt.mask)
		end
		if (s_axi_bvalid === 1'h1 && s_axi_bready && wq.size() > 0)
		begin
			nt = wq.pop_front();
			`RPDS_CMP("bresp", nt.resp, s_axi_bresp)
		end
	end

	// ************
	// bus tasks
	// ************
	task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_h, w_h, b_h;
		wq.push_back('{r, 32'h0, 32'h0});
		b_h = 1'h0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		while (!b_h)
		begin
			@(negedge aclk);
			aw_h = s_axi_awvalid && s_axi_awready;
			w_h  = s_axi_wvalid && s_axi_wready;
			b_h  = s_axi_bvalid && s_axi_bready;
			@(posedge aclk);
			if (aw_h) s_axi_awvalid <= 1'h0;
			if (w_h) s_axi_wvalid <= 1'h0;
			if (b_h) s_axi_bready <= 1'h0;
		end
	endtask : bus_wr

	task automatic bus_rd(input logic [11:0] a, input logic [31:0] e, m, input logic [1:0] r);
		logic ar_h, r_h;
		rq.push_back('{r, e, m});
		r_h = 1'h0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		while (!r_h)
		begin
			@(negedge aclk);
			ar_h = s_axi_arvalid && s_axi_arready;
			r_h  = s_axi_rvalid && s_axi_rready;
			@(posedge aclk);
			if (ar_h) s_axi_arvalid <= 1'h0;
			if (r_h) s_axi_rready <= 1'h0;
		end
	endtask : bus_rd

	// ************
	// reset tasks
	// ************
	task automatic drop_wait();
		for (t = 0; t < 30 && chip_rst_n !== 1'h0; t++) @(negedge aclk);
		`RPDS_CMP("chip_rst_n low", 1'h0, chip_rst_n)
		`RPDS_CMP("swd in reset", 1'h0, swd_enable)
	endtask : drop_wait

	task automatic run_wait();
		logic seen;
		seen = 1'h0;
		for (t = 0; t < 200 && chip_rst_n !== 1'h1; t++)
		begin
			seen = seen | (flash_init === 1'h1);
			@(negedge aclk);
		end
		`RPDS_CMP("chip_rst_n high", 1'h1, chip_rst_n)
		`RPDS_CMP("flash init seen", 1'h1, seen)
		`RPDS_CMP("osc_enable", 1'h1, osc_enable)
		`RPDS_CMP("fetch_addr", `RPDS_RESET_VECTOR, fetch_addr)
		`RPDS_CMP("bscan_cpu_debug", 1'h0, bscan_cpu_debug)
	endtask : run_wait

	// one source: 0 watchdog, 1 supply-up, 2 brownout, 3 pin pulse of 10 cycles
	task automatic src_hit(input int k);
		@(posedge aclk);
		case (k)
			0: watchdog_rst <= 1'h1;
			1: power_ok <= 1'h0;
			2: rst_drop <= 1'h1;
			default: pin_go <= 1'h1;
		endcase
		pin_len <= 8'h0A;
		@(posedge aclk);
		pin_go <= 1'h0;
		drop_wait();
		@(posedge aclk);
		watchdog_rst <= 1'h0;
		power_ok     <= 1'h1;
		rst_drop     <= 1'h0;
		run_wait();
	endtask : src_hit

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	// watchdog against a hung run
	initial
	begin
		#(80000 * 5);
		n_fail++;
		print_verdict();
	end

	// ************
	// main sequence
	// ************
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		run_wait();
		bus_rd(`RPDS_OFF_CTRL, `RPDS_CTRL_RESET, 32'hFFFFFFFF, 2'h0);
		bus_rd(`RPDS_OFF_ID, `RPDS_ID_VALUE, 32'hFFFFFFFF, 2'h0);
		bus_rd(`RPDS_OFF_BOOT, 32'h0, 32'hFFFFFFFF, 2'h0);
		bus_rd(12'h020, 32'h0, 32'h0, 2'h2);
		bus_wr(`RPDS_OFF_STATUS, 32'hFFFFFFFF, 2'h2);
		bus_rd(`RPDS_OFF_CTRL, `RPDS_CTRL_RESET, 32'hFFFFFFFF, 2'h0);
		for (i = 0; i < 4; i++) src_hit(i);
		// pulses of 1 and 9 cycles stay below the filter and leave the chip running
		for (i = 1; i < 10; i += 8)
		begin
			@(posedge aclk);
			pin_go  <= 1'h1;
			pin_len <= 8'(i);
			@(posedge aclk);
			pin_go <= 1'h0;
			repeat (14) @(negedge aclk);
			`RPDS_CMP("short pulse", 1'h1, chip_rst_n)
		end
		// brownout interrupt at each selectable level, then masked and unselected
		for (i = 0; i < 3; i++)
		begin
			lfsr_q = lfsr_next(lfsr_q);
			bus_wr(`RPDS_OFF_CTRL, 32'h0C | i, 2'h0);
			brown_level <= lfsr_q[2:0];
			repeat (2) @(negedge aclk);
			`RPDS_CMP("brownout_irq", lfsr_q[i], brownout_irq)
			bus_rd(`RPDS_OFF_STATUS, {28'h1, 2'h1, {2{lfsr_q[i]}}}, 32'h3F, 2'h0);
		end
		brown_level <= 3'h7;
		bus_wr(`RPDS_OFF_CTRL, 32'h08, 2'h0);
		@(negedge aclk);
		`RPDS_CMP("irq disabled", 1'h0, brownout_irq)
		bus_wr(`RPDS_OFF_CTRL, 32'h0F, 2'h0);
		@(negedge aclk);
		`RPDS_CMP("irq no level", 1'h0, brownout_irq)
		bus_wr(`RPDS_OFF_CTRL, 32'h18, 2'h0);
		brown_level <= 3'h0;
		@(negedge aclk);
		`RPDS_CMP("pin entry off", 1'h0, perm.isp_pin_allow)
		`RPDS_CMP("swd kept", 1'h1, perm.swd_allow)
		bus_wr(`RPDS_OFF_CTRL, 32'h08, 2'h0);
		// upper byte lanes only: the low control byte keeps its value
		s_axi_wstrb <= 4'hE;
		bus_wr(`RPDS_OFF_CTRL, 32'h17, 2'h0);
		s_axi_wstrb <= 4'hF;
		bus_rd(`RPDS_OFF_CTRL, 32'h08, 32'h1F, 2'h0);
		// guard patterns, the no-isp pattern, then a word that matches none
		pats = '{`RPDS_GUARD_PAT1, `RPDS_GUARD_PAT2, `RPDS_GUARD_PAT3, `RPDS_NO_ISP_PAT, {4{lfsr_q}}};
		sector0_target <= 1'h1;
		for (i = 0; i < 5; i++)
		begin
			guard_word <= pats[i];
			src_hit(0);
			lv = (i < 3) ? i + 1 : 0;
			`RPDS_CMP("swd_allow", (lv == 0), perm.swd_allow)
			`RPDS_CMP("swd_enable", (lv == 0), swd_enable)
			`RPDS_CMP("isp_allow", (lv != 3), perm.isp_allow)
			`RPDS_CMP("isp_pin_allow", (lv != 3 && i != 3), perm.isp_pin_allow)
			`RPDS_CMP("iap_allow", 1'h1, perm.iap_allow)
			if (lv == 1) `RPDS_CMP("isp_partial", 1'h1, perm.isp_partial)
			`RPDS_CMP("sector0", (lv == 0 || lv == 2), isp_sector0_ok)
			if (lv == 2) `RPDS_CMP("isp_full_only", 1'h1, perm.isp_full_only)
			bus_rd(`RPDS_OFF_GUARD, {29'h0, (i == 3), 2'(lv)}, 32'h7, 2'h0);
		end
		// boundary scan entry by the test host
		@(posedge aclk);
		scan_req <= 1'h1;
		for (t = 0; t < 60000 && scan_ready !== 1'h1; t++) @(negedge aclk);
		repeat (20) @(negedge aclk);
		drop_wait();
		`RPDS_CMP("bscan_enable", 1'h1, bscan_enable)
		`RPDS_CMP("tap_pin_route", 1'h1, tap_pin_route)
		`RPDS_CMP("cpu debug in scan", 1'h0, bscan_cpu_debug)
		@(posedge aclk);
		scan_req <= 1'h0;
		run_wait();
		`RPDS_CMP("bscan off", 1'h0, bscan_enable)
		`RPDS_CMP("swd on", 1'h1, swd_enable)
		`RPDS_CMP("notes left", 0, rq.size() + wq.size())
		print_verdict();
	end
endmodule : tb_top

/* File: hw/rpds_cfg.svh */
/*
 * constants for the reset, protection and debug select block
 * assumes inclusion by bare name from the package and the design file
 */
`ifndef RPDS_CFG_SVH
`define RPDS_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define RPDS_OFF_CTRL        12'h000
`define RPDS_OFF_STATUS      12'h004
`define RPDS_OFF_GUARD       12'h008
`define RPDS_OFF_BOOT        12'h00C
`define RPDS_OFF_ID          12'h010

// ************************************************************
// control fields
// ************************************************************
`define RPDS_CTRL_IRQ_SEL_LO 0
`define RPDS_CTRL_IRQ_EN     2
`define RPDS_CTRL_RST_EN     3
`define RPDS_CTRL_ISP_PIN_DIS 4
`define RPDS_CTRL_RESET      32'h0000_0008

// ************************************************************
// protection patterns in the dedicated flash word
// ************************************************************
`define RPDS_GUARD_PAT1      32'h1234_5678
`define RPDS_GUARD_PAT2      32'h8765_4321
`define RPDS_GUARD_PAT3      32'h4321_8765
`define RPDS_NO_ISP_PAT      32'h4E69_7370

// ************************************************************
// timing
// ************************************************************
`define RPDS_CLK_MHZ         200
`define RPDS_PIN_MIN_NS      50
`define RPDS_PIN_MIN_CYC     ((`RPDS_PIN_MIN_NS * `RPDS_CLK_MHZ + 999) / 1000)
`define RPDS_FLASH_INIT_CYC  16
`define RPDS_RESET_VECTOR    32'h0000_0000
`define RPDS_ID_VALUE        32'h0000_0A5A

`endif

/* File: hw/rpds_pkg.sv */
/*
 * types for the reset, protection and debug select block
 * assumes rpds_cfg.svh beside it
 */
`include "rpds_cfg.svh"

package rpds_pkg;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		RPDS_GUARD_NONE,
		RPDS_GUARD_ONE,
		RPDS_GUARD_TWO,
		RPDS_GUARD_THREE
	} rpds_guard_t;

	typedef enum {
		RPDS_ST_HOLD,
		RPDS_ST_OSC,
		RPDS_ST_FLASH,
		RPDS_ST_RUN
	} rpds_state_t;

	// debug, isp and iap permissions travel together
	typedef struct packed {
		logic swd_allow;
		logic isp_allow;
		logic isp_partial;
		logic isp_full_only;
		logic isp_pin_allow;
		logic iap_allow;
	} rpds_perm_t;

	// raw supply monitor comparator outputs
	typedef struct packed {
		logic [2:0] below_irq;
		logic       below_rst;
		logic       supply_ok;
	} rpds_supply_t;

endpackage : rpds_pkg

/* File: hw/rpds_top.sv */
/*
 * reset merge, start-up sequence, brownout reporting, code read guard
 * and debug/boundary-scan selection behind an axi4-lite slave
 * assumes synchronous inputs, one 200 MHz clock, flash guard word valid
 * from reset
 */
// What this block does
// - any of pin, watchdog, supply-up or brownout reset asserts chip reset.
// - after reset with usable supply, start fast oscillator then flash init.
// - a low reset pin pulse of 50 ns or longer is a reset.
// - on reset release the processor fetches from address 0.
// - ctrl_reg and the bus registers reset only on aresetn, not on internal reset.
// - three selectable brownout interrupt levels, one reset level, irq out.
// - brownout interrupt level readable as a status bit for polling.
// - supply below the reset level forces a full chip reset.
// - guard activates only on a specific pattern in the guard flash word.
// - in-application programming works at every guard level.
// - isp entry by pin can be disabled without enabling the guard.
// - level one blocks debug, partial isp update, never sector 0.
// - level two blocks debug, allows only full erase and reprogram.
// - level three blocks debug and all isp, including pin entry.
// - reset pin low selects boundary scan, high selects serial debug.
// - serial debug stays disabled while the device is in reset.
// - boundary-scan mode routes test port pins by hardware.
// - boundary-scan port gives no processor debug access.
`timescale 1ns/1ps
`include "rpds_cfg.svh"

module rpds_top (
	// clock and bus reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// reset sources
	input  wire logic                  reset_pin_n,
	input  wire logic                  watchdog_rst,
	input  wire rpds_pkg::rpds_supply_t supply,
	// dedicated flash guard word
	input  wire logic [31:0]           guard_word,
	input  wire logic                  sector0_target,
	// axi4-lite
	input  wire logic [11:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [11:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// system outputs
	output logic                       chip_rst_n,
	output logic                       osc_enable,
	output logic                       flash_init,
	output logic [31:0]                fetch_addr,
	output logic                       brownout_irq,
	// permissions and debug select
	output rpds_pkg::rpds_perm_t       perm,
	output logic                       isp_sector0_ok,
	output logic                       swd_enable,
	output logic                       bscan_enable,
	output logic                       tap_pin_route,
	output logic                       bscan_cpu_debug
);

	localparam int PIN_CYC   = `RPDS_PIN_MIN_CYC;
	localparam int FLASH_CYC = `RPDS_FLASH_INIT_CYC;
	localparam logic [3:0] FLASH_LAST = 4'(FLASH_CYC - 1);

	initial
	begin
		if (PIN_CYC < 1 || PIN_CYC > 255 || FLASH_CYC < 1 || FLASH_CYC > 16)
			$error("rpds_top: timing counts out of range");
	end

	// ************************************************************
	// reset pin filter and merge
	// ************************************************************
	logic [7:0]  pin_low_reg;
	logic        pin_req;
	logic        bod_rst_req;
	logic        src_rst;
	logic [1:0]  sync_reg;
	logic [31:0] ctrl_reg;

	// count consecutive low cycles; request once the minimum width is met
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pin_low_reg <= 8'h00;
		else if (reset_pin_n)
			pin_low_reg <= 8'h00;
		else if (pin_low_reg != 8'(PIN_CYC))
			pin_low_reg <= pin_low_reg + 8'h01;
	end

	assign pin_req     = (pin_low_reg == 8'(PIN_CYC));
	assign bod_rst_req = supply.below_rst & ctrl_reg[`RPDS_CTRL_RST_EN];
	assign src_rst     = !aresetn | pin_req | watchdog_rst
	                   | !supply.supply_ok | bod_rst_req;

	// assert at once, release through two stages
	always_ff @(posedge aclk or posedge src_rst)
	begin
		if (src_rst)
			sync_reg <= 2'b00;
		else
			sync_reg <= {sync_reg[0], 1'b1};
	end

	// ************************************************************
	// start-up sequence
	// ************************************************************
	rpds_pkg::rpds_state_t state_reg;
	logic [3:0]            init_cnt_reg;

	// hold, start oscillator, initialise flash, then run
	always_ff @(posedge aclk)
	begin
		if (!sync_reg[1])
		begin
			state_reg    <= rpds_pkg::RPDS_ST_HOLD;
			init_cnt_reg <= 4'h0;
		end
		else
		begin
			case (state_reg)
				rpds_pkg::RPDS_ST_HOLD:
					state_reg <= rpds_pkg::RPDS_ST_OSC;
				rpds_pkg::RPDS_ST_OSC:
					state_reg <= rpds_pkg::RPDS_ST_FLASH;
				rpds_pkg::RPDS_ST_FLASH:
				begin
					if (init_cnt_reg == FLASH_LAST)
						state_reg <= rpds_pkg::RPDS_ST_RUN;
					else
						init_cnt_reg <= init_cnt_reg + 4'h1;
				end
				rpds_pkg::RPDS_ST_RUN:
					state_reg <= rpds_pkg::RPDS_ST_RUN;
				default:
					state_reg <= rpds_pkg::RPDS_ST_HOLD;
			endcase
		end
	end

	assign osc_enable = (state_reg != rpds_pkg::RPDS_ST_HOLD);
	assign flash_init = (state_reg == rpds_pkg::RPDS_ST_FLASH);
	assign chip_rst_n = (state_reg == rpds_pkg::RPDS_ST_RUN);
	assign fetch_addr = `RPDS_RESET_VECTOR;

	// ************************************************************
	// brownout interrupt
	// ************************************************************
	logic [1:0] irq_sel;
	logic       bod_level;

	assign irq_sel      = ctrl_reg[`RPDS_CTRL_IRQ_SEL_LO +: 2];
	assign bod_level    = (irq_sel < 2'h3) ? supply.below_irq[irq_sel] : 1'b0;
	assign brownout_irq = bod_level & ctrl_reg[`RPDS_CTRL_IRQ_EN];

	// ************************************************************
	// code read guard
	// ************************************************************
	rpds_pkg::rpds_guard_t guard_reg;
	logic                  no_isp_pin_reg;

	// sample the guard word while the chip is held in reset
	always_ff @(posedge aclk)
	begin
		if (!chip_rst_n)
		begin
			case (guard_word)
				`RPDS_GUARD_PAT1: guard_reg <= rpds_pkg::RPDS_GUARD_ONE;
				`RPDS_GUARD_PAT2: guard_reg <= rpds_pkg::RPDS_GUARD_TWO;
				`RPDS_GUARD_PAT3: guard_reg <= rpds_pkg::RPDS_GUARD_THREE;
				default:          guard_reg <= rpds_pkg::RPDS_GUARD_NONE;
			endcase
			no_isp_pin_reg <= (guard_word == `RPDS_NO_ISP_PAT);
		end
	end

	// permissions from guard level
	always_comb
	begin
		perm.iap_allow     = 1'b1;
		perm.swd_allow     = (guard_reg == rpds_pkg::RPDS_GUARD_NONE);
		perm.isp_allow     = (guard_reg != rpds_pkg::RPDS_GUARD_THREE);
		perm.isp_partial   = (guard_reg == rpds_pkg::RPDS_GUARD_ONE);
		perm.isp_full_only = (guard_reg == rpds_pkg::RPDS_GUARD_TWO);
		perm.isp_pin_allow = perm.isp_allow & !no_isp_pin_reg
		                   & !ctrl_reg[`RPDS_CTRL_ISP_PIN_DIS];
	end

	assign isp_sector0_ok = (guard_reg == rpds_pkg::RPDS_GUARD_NONE)
	                      | (perm.isp_full_only & sector0_target);

	// ************************************************************
	// debug and boundary scan select
	// ************************************************************
	assign bscan_enable    = !reset_pin_n;
	assign swd_enable      = reset_pin_n & chip_rst_n & perm.swd_allow;
	assign tap_pin_route   = bscan_enable;
	assign bscan_cpu_debug = 1'b0;

	// ************************************************************
	// axi4-lite slave
	// ************************************************************
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        wr_go;
	logic [31:0] rd_val;
	logic        rd_ok;

	assign s_axi_awready = !aw_held_reg & !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg & !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_held_reg & w_held_reg;

	// capture address and data in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= 12'h000;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_held_reg <= 1'b0;
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			else if (wr_go)
				w_held_reg <= 1'b0;
		end
	end

	// control register writes with byte lanes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_reg <= `RPDS_CTRL_RESET;
		else if (wr_go && awaddr_reg[11:2] == 10'(`RPDS_OFF_CTRL >> 2))
		begin
			for (int i = 0; i < 4; i++)
				if (wstrb_reg[i])
					ctrl_reg[8*i +: 8] <= wdata_reg[8*i +: 8];
		end
	end

	// write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_reg[11:2] == 10'(`RPDS_OFF_CTRL >> 2)) ? 2'b00 : 2'b10;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read mux
	always_comb
	begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		case (s_axi_araddr[11:2])
			10'(`RPDS_OFF_CTRL >> 2):   rd_val = {27'h0, ctrl_reg[4:0]};
			10'(`RPDS_OFF_STATUS >> 2): rd_val = {26'h0, supply.below_rst, swd_enable,
			                                 bscan_enable, chip_rst_n, brownout_irq,
			                                 bod_level};
			10'(`RPDS_OFF_GUARD >> 2):  rd_val = {29'h0, no_isp_pin_reg, guard_reg};
			10'(`RPDS_OFF_BOOT >> 2):   rd_val = fetch_addr;
			10'(`RPDS_OFF_ID >> 2):     rd_val = `RPDS_ID_VALUE;         // arbitrary value
			default:               rd_ok  = 1'b0;
		endcase
	end

	// read response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'b00;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ************************************************************
	// assertions
	// ************************************************************
	sequence s_pin_low;
		!reset_pin_n [*8];
	endsequence

	sequence s_held;
		!chip_rst_n [*2];
	endsequence

	property p_pin_reset;
		@(posedge aclk) disable iff (!aresetn) s_pin_low ##1 !reset_pin_n [*2] |-> ##2 !chip_rst_n;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin low did not reset");

	property p_short_ok;
		@(posedge aclk) disable iff (!aresetn)
			chip_rst_n && $fell(reset_pin_n) ##1 reset_pin_n |-> chip_rst_n;
	endproperty
	a_short_ok: assert property (p_short_ok) else $error("short pulse caused reset");

	property p_wdog;
		@(posedge aclk) disable iff (!aresetn) watchdog_rst |-> ##1 !chip_rst_n;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog reset missed");

	property p_bod_rst;
		@(posedge aclk) disable iff (!aresetn)
			supply.below_rst && ctrl_reg[`RPDS_CTRL_RST_EN] |-> ##1 !chip_rst_n;
	endproperty
	a_bod_rst: assert property (p_bod_rst) else $error("brownout reset missed");

	property p_startup;
		@(posedge aclk) disable iff (!aresetn)
			s_held ##1 $rose(chip_rst_n) |-> $past(flash_init) && osc_enable;
	endproperty
	a_startup: assert property (p_startup) else $error("release without flash init");

	property p_release_len;
		@(posedge aclk) disable iff (!aresetn)
			$rose(sync_reg[1]) |-> !chip_rst_n [*8] ##[1:20] chip_rst_n;
	endproperty
	a_release_len: assert property (p_release_len) else $error("start-up length wrong");

	property p_swd_off;
		@(posedge aclk) disable iff (!aresetn) !chip_rst_n || !reset_pin_n |-> !swd_enable;
	endproperty
	a_swd_off: assert property (p_swd_off) else $error("debug open in reset");

	property p_guard_swd;
		@(posedge aclk) disable iff (!aresetn)
			guard_reg != rpds_pkg::RPDS_GUARD_NONE |-> !swd_enable && perm.iap_allow;
	endproperty
	a_guard_swd: assert property (p_guard_swd) else $error("debug open under guard");

	property p_lvl3;
		@(posedge aclk) disable iff (!aresetn)
			guard_reg == rpds_pkg::RPDS_GUARD_THREE |-> !perm.isp_allow && !perm.isp_pin_allow;
	endproperty
	a_lvl3: assert property (p_lvl3) else $error("isp open at level three");

	property p_irq;
		@(posedge aclk) disable iff (!aresetn)
			ctrl_reg[`RPDS_CTRL_IRQ_EN] && irq_sel == 2'h1 |-> brownout_irq == supply.below_irq[1];
	endproperty
	a_irq: assert property (p_irq) else $error("brownout irq level wrong");

endmodule : rpds_top
